// file: tb.sv
// Self-checking bench of the frame timer
`include "uft_defs.svh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [13:0] LEN = 14'h0014;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ctrl_reset = 1'b0;
   logic running_state = 1'b0;
   logic ls_request = 1'b0;
   logic cmd_valid, rd_valid, ls_grant, ls_deny, sof_flag, ok;
   logic [7:0] cmd_code;
   logic [31:0] cmd_wdata, rd_data, q;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   uft_top i_uft_top (.clk(clk), .reset(reset), .ctrl_reset(ctrl_reset),
      .running_state(running_state), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .ls_request(ls_request),
      .ls_grant(ls_grant), .ls_deny(ls_deny), .sof_flag(sof_flag));
   uft_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));
   // ****
   // Helpers
   // ****
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] c, input logic [31:0] e, input string n);
      host.xfer(c, 32'h0000_0000, q, ok);
      `CHK(n, 1'b1, ok);
      `CHK(n, e, q);
   endtask
   task automatic wait_sof();
      do @(posedge clk);
      while (sof_flag !== 1'b1);
   endtask
   // Query k cycles after a frame start sees remaining LEN-1-k
   task automatic ls_probe(input int k, input logic e);
      wait_sof();
      repeat (k) @(posedge clk);
      ls_request <= 1'b1;
      @(posedge clk);
      ls_request <= 1'b0;
      @(posedge clk);
      `CHK("ls_grant", e, ls_grant);
      `CHK("ls_deny", !e, ls_deny);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      rd(`UFT_CMD_RD_REMAIN, 32'h0000_0000, "remaining");
      rd(`UFT_CMD_RD_NUMBER, 32'h0000_0000, "number");
      rd(`UFT_CMD_RD_THRESH, 32'h0000_0628, "threshold");
      rd(`UFT_CMD_RD_LENGTH, 32'h0000_2EDF, "length");
      host.xfer(8'h55, 32'h0000_0000, q, ok);
      `CHK("unknown code", 1'b0, ok);
      $display("t_reset done");
   endtask
   task automatic t_frame();
      int n;
      host.set_length(LEN);
      rd(`UFT_CMD_RD_LENGTH, {1'b1, 17'h0_0000, LEN}, "length");
      running_state <= 1'b1;
      wait_sof();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sof_flag !== 1'b1);
      `CHK("period", LEN + 14'h1, n);
      rd(`UFT_CMD_RD_REMAIN, {1'b1, 17'h0_0000, LEN - 14'h1}, "remaining");
      rd(`UFT_CMD_RD_NUMBER, 32'h0000_0002, "number");
      // Software widens the 16-bit number into a 32-bit frame count
      `CHK("frame count ext", 32'h0000_0002, {16'h0000, q[15:0]});
      $display("t_frame done");
   endtask
   task automatic t_ls();
      ls_probe(0, 1'b0);
      // Threshold set once only; it is never written again
      host.xfer(`UFT_CMD_WR_THRESH, 32'hFFFF_F805, q, ok);
      rd(`UFT_CMD_RD_THRESH, 32'h0000_0005, "threshold");
      ls_probe(14, 1'b1);
      ls_probe(15, 1'b0);
      $display("t_ls done");
   endtask
   task automatic t_ctrl();
      running_state <= 1'b0;
      ctrl_reset <= 1'b1;
      @(posedge clk);
      ctrl_reset <= 1'b0;
      @(posedge clk);
      // Controller reset restores the length field only; the toggle keeps its value
      rd(`UFT_CMD_RD_LENGTH, 32'h8000_2EDF, "length");
      $display("t_ctrl done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_frame();
      t_ls();
      t_ctrl();
      close_out();
   end
endmodule

// file: uft_cfg_if.sv
// Configuration carried from register port to frame counter
interface uft_cfg_if;
   import uft_pkg::*;
   uft_count_t frame_length;
   logic interval_toggle;
   modport src (output frame_length, output interval_toggle);
   modport dst (input frame_length, input interval_toggle);
endinterface

// file: uft_defs.svh
// Constants of the USB host frame timer
`ifndef UFT_DEFS_SVH
`define UFT_DEFS_SVH
`define UFT_CMD_RD_REMAIN 8'h0E
`define UFT_CMD_RD_NUMBER 8'h0F
`define UFT_CMD_RD_THRESH 8'h11
`define UFT_CMD_WR_THRESH 8'h91
`define UFT_CMD_RD_LENGTH 8'h0D
`define UFT_CMD_WR_LENGTH 8'h8D
`define UFT_LEN_DEFAULT 14'h2EDF
`define UFT_THR_DEFAULT 11'h628
`define UFT_BIT_TOGGLE 31
`define UFT_CNT_W 14
`define UFT_THR_W 11
`define UFT_NUM_W 16
`define UFT_ZERO_CNT 14'h0000
`define UFT_ONE_CNT 14'h0001
`define UFT_ONE_NUM 16'h0001
`define UFT_ZERO_WORD 32'h0000_0000
`endif

// file: uft_frame_ctr.sv
// Frame counter: bit time down counter and frame number
`include "uft_defs.svh"
module uft_frame_ctr
   import uft_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic start,
   input wire logic run,
   uft_cfg_if.dst cfg,
   // State
   output uft_count_t bit_time_left,
   output logic remaining_toggle,
   output uft_number_t frame_count,
   output logic sof_pulse
);
   uft_count_t left_reg, left_next;
   logic tog_reg, tog_next;
   uft_number_t num_reg, num_next;
   logic sof_reg, sof_next;

   always_comb begin
      left_next = left_reg;
      tog_next = tog_reg;
      num_next = num_reg;
      sof_next = 1'b0;
      if (start) begin
         left_next = cfg.frame_length;
         num_next = num_reg + `UFT_ONE_NUM;
         sof_next = 1'b1;
      end else if (run) begin
         if (left_reg == `UFT_ZERO_CNT) begin
            left_next = cfg.frame_length;
            tog_next = cfg.interval_toggle;
            num_next = num_reg + `UFT_ONE_NUM;
            sof_next = 1'b1;
         end else begin
            left_next = left_reg - `UFT_ONE_CNT;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         left_reg <= `UFT_ZERO_CNT;
         tog_reg <= 1'b0;
         num_reg <= '0;
         sof_reg <= 1'b0;
      end else begin
         left_reg <= left_next;
         tog_reg <= tog_next;
         num_reg <= num_next;
         sof_reg <= sof_next;
      end
   end

   assign bit_time_left = left_reg;
   assign remaining_toggle = tog_reg;
   assign frame_count = num_reg;
   assign sof_pulse = sof_reg;
endmodule

// file: uft_host_model.sv
// Host processor model issuing command-coded accesses
`include "uft_defs.svh"
module uft_host_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [31:0] cmd_wdata,
   input wire logic [31:0] rd_data,
   input wire logic rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic toggle_reg = 1'b0;
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 32'h0000_0000;
   end
   // Called just after a rising edge; data inverted once released
   task automatic xfer(input logic [7:0] c, input logic [31:0] w, output logic [31:0] r,
      output logic v);
      cmd_code <= c;
      cmd_wdata <= w;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_wdata <= ~w;
      @(posedge clk);
      r = rd_data;
      v = rd_valid;
   endtask
   // Reserved bits sent high so that ignoring them is visible
   task automatic set_length(input logic [13:0] len);
      logic [31:0] r;
      logic v;
      toggle_reg = ~toggle_reg;
      xfer(`UFT_CMD_WR_LENGTH, {toggle_reg, 17'h1_FFFF, len}, r, v);
   endtask
endmodule

// file: uft_pkg.sv
// Types shared by the USB host frame timer modules
package uft_pkg;
   typedef logic [13:0] uft_count_t;
   typedef logic [15:0] uft_number_t;
   typedef logic [10:0] uft_thresh_t;
   typedef enum logic [1:0] {
      UFT_IDLE = 2'b00,
      UFT_START = 2'b01,
      UFT_RUN = 2'b10
   } uft_state_t;
endpackage

// file: uft_reg_port.sv
// Command-coded register port of the frame timer
`include "uft_defs.svh"
module uft_reg_port
   import uft_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ctrl_reset,
   // Command
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [31:0] cmd_wdata,
   // Stored values
   uft_cfg_if.src cfg,
   output uft_thresh_t slow_commit_limit
);
   uft_count_t len_reg, len_next;
   logic fit_reg, fit_next;
   uft_thresh_t thr_reg, thr_next;

   always_comb begin
      len_next = len_reg;
      fit_next = fit_reg;
      thr_next = thr_reg;
      if (ctrl_reset) begin
         len_next = `UFT_LEN_DEFAULT;
      end else if (cmd_valid && cmd_code == `UFT_CMD_WR_LENGTH) begin
         len_next = cmd_wdata[`UFT_CNT_W-1:0];
         fit_next = cmd_wdata[`UFT_BIT_TOGGLE];
      end
      // Only low 11 bits kept, upper bits dropped
      if (cmd_valid && cmd_code == `UFT_CMD_WR_THRESH) begin
         thr_next = cmd_wdata[`UFT_THR_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         len_reg <= `UFT_LEN_DEFAULT;
         fit_reg <= 1'b0;
         thr_reg <= `UFT_THR_DEFAULT;
      end else begin
         len_reg <= len_next;
         fit_reg <= fit_next;
         thr_reg <= thr_next;
      end
   end

   assign cfg.frame_length = len_reg;
   assign cfg.interval_toggle = fit_reg;
   assign slow_commit_limit = thr_reg;
endmodule

// file: uft_top.sv
// Top of the USB host frame timer
`include "uft_defs.svh"
module uft_top
   import uft_pkg::*;
(
   // Clock and reset
   clk,
   reset,
   // Controller state
   ctrl_reset,
   running_state,
   // Command port
   cmd_valid,
   cmd_code,
   cmd_wdata,
   rd_data,
   rd_valid,
   // Low-speed commit check
   ls_request,
   ls_grant,
   ls_deny,
   // Frame events
   sof_flag
);
   input wire logic clk;
   input wire logic reset;
   input wire logic ctrl_reset;
   input wire logic running_state;
   input wire logic cmd_valid;
   input wire logic [7:0] cmd_code;
   input wire logic [31:0] cmd_wdata;
   output logic [31:0] rd_data;
   output logic rd_valid;
   input wire logic ls_request;
   output logic ls_grant;
   output logic ls_deny;
   output logic sof_flag;

   // ****************************************
   // State machine and submodules
   // ****************************************
   uft_state_t state_reg, state_next;
   uft_cfg_if cfg_bus ();
   uft_count_t bit_time_left;
   uft_number_t frame_count;
   uft_thresh_t slow_commit_limit;
   logic remaining_toggle;
   logic sof_pulse;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         UFT_IDLE: begin
            if (running_state) begin
               state_next = UFT_START;
            end
         end
         UFT_START: begin
            state_next = running_state ? UFT_RUN : UFT_IDLE;
         end
         UFT_RUN: begin
            if (!running_state) begin
               state_next = UFT_IDLE;
            end
         end
         default: begin
            state_next = UFT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset || ctrl_reset) begin
         state_reg <= UFT_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   uft_reg_port u_regs (
      .clk(clk),
      .reset(reset),
      .ctrl_reset(ctrl_reset),
      .cmd_valid(cmd_valid),
      .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata),
      .cfg(cfg_bus.src),
      .slow_commit_limit(slow_commit_limit)
   );

   uft_frame_ctr u_ctr (
      .clk(clk),
      .reset(reset),
      .start(state_reg == UFT_START),
      .run(state_reg == UFT_RUN),
      .cfg(cfg_bus.dst),
      .bit_time_left(bit_time_left),
      .remaining_toggle(remaining_toggle),
      .frame_count(frame_count),
      .sof_pulse(sof_pulse)
   );

   // ****************************************
   // Read data and low-speed check
   // ****************************************
   logic [31:0] rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic grant_reg, grant_next;
   logic deny_reg, deny_next;

   // Unknown codes answer zero with no valid, so other blocks can share the port
   always_comb begin
      rd_data_next = `UFT_ZERO_WORD;
      rd_valid_next = 1'b0;
      if (cmd_valid) begin
         unique case (cmd_code)
            `UFT_CMD_RD_REMAIN: begin
               rd_data_next[`UFT_BIT_TOGGLE] = remaining_toggle;
               rd_data_next[`UFT_CNT_W-1:0] = bit_time_left;
               rd_valid_next = 1'b1;
            end
            `UFT_CMD_RD_NUMBER: begin
               rd_data_next[`UFT_NUM_W-1:0] = frame_count;
               rd_valid_next = 1'b1;
            end
            `UFT_CMD_RD_THRESH: begin
               rd_data_next[`UFT_THR_W-1:0] = slow_commit_limit;
               rd_valid_next = 1'b1;
            end
            `UFT_CMD_RD_LENGTH: begin
               rd_data_next[`UFT_BIT_TOGGLE] = cfg_bus.interval_toggle;
               rd_data_next[`UFT_CNT_W-1:0] = cfg_bus.frame_length;
               rd_valid_next = 1'b1;
            end
            default: begin
               rd_valid_next = 1'b0;
            end
         endcase
      end
      // Threshold zero-extended to counter width for compare
      grant_next = ls_request && (state_reg == UFT_RUN)
         && (bit_time_left >= {3'b000, slow_commit_limit});
      deny_next = ls_request && !grant_next;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_reg <= `UFT_ZERO_WORD;
         rd_valid_reg <= 1'b0;
         grant_reg <= 1'b0;
         deny_reg <= 1'b0;
      end else begin
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
         grant_reg <= grant_next;
         deny_reg <= deny_next;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign ls_grant = grant_reg;
   assign ls_deny = deny_reg;
   assign sof_flag = sof_pulse;
endmodule

// file: uft_top_properties.sv
// Port assertions of the frame timer
`include "uft_defs.svh"
module uft_top_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic ctrl_reset,
   // Stimulus and answers
   input wire logic running_state,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [31:0] rd_data,
   input wire logic rd_valid,
   input wire logic ls_request,
   input wire logic ls_grant,
   input wire logic ls_deny,
   input wire logic sof_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic rd_cmd;
   assign rd_cmd = cmd_valid && cmd_code inside {`UFT_CMD_RD_REMAIN, `UFT_CMD_RD_NUMBER,
      `UFT_CMD_RD_THRESH, `UFT_CMD_RD_LENGTH};
   a_rd_answer: assert property (rd_cmd |=> rd_valid)
      else $error("read got no answer");
   a_wr_silent: assert property (cmd_valid && !rd_cmd |=> !rd_valid)
      else $error("write or unknown code answered");
   a_rd_idle: assert property (!rd_valid |-> rd_data == 32'h0000_0000)
      else $error("read data without a read");
   a_rem_resv: assert property (cmd_valid && cmd_code == `UFT_CMD_RD_REMAIN
      |=> rd_data[30:14] == 17'h0_0000)
      else $error("remaining reserved bits set");
   a_num_resv: assert property (cmd_valid && cmd_code == `UFT_CMD_RD_NUMBER
      |=> rd_data[31:16] == 16'h0000)
      else $error("number reserved bits set");
   a_ls_answer: assert property (ls_request |=> ls_grant != ls_deny)
      else $error("query not answered once");
   a_ls_quiet: assert property (!ls_request |=> !ls_grant && !ls_deny)
      else $error("answer without query");
   a_sof_single: assert property (sof_flag |=> !sof_flag)
      else $error("start of frame flag too long");
   a_sof_start: assert property (disable iff (reset || ctrl_reset)
      $rose(running_state) |-> ##[1:4] sof_flag)
      else $error("no frame start on entering run");
endmodule
bind uft_top uft_top_properties i_props (.clk(clk), .reset(reset), .ctrl_reset(ctrl_reset),
   .running_state(running_state), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .rd_data(rd_data), .rd_valid(rd_valid), .ls_request(ls_request),
   .ls_grant(ls_grant), .ls_deny(ls_deny), .sof_flag(sof_flag));
